// ===== pkg/rci_pkg.sv
package rci_pkg;

	// ************************************************
	// Clock and timing
	// ************************************************
	localparam int CLK_HZ = 125000000;
	localparam int CLK_PERIOD_PS = 8000;
	localparam int BAUD_LOW = 921600;
	localparam int BAUD_HIGH = 4000000;
	localparam logic [15:0] DIV_RST = 16'(CLK_HZ / BAUD_LOW);
	localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / BAUD_HIGH);
	localparam int T_GAP_MIN_PS = 25000;
	localparam int T_GAP_MIN_CYC = (T_GAP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int T_SAMPLE_MAX_US = 100;
	localparam int T_SAMPLE_MAX_CYC = T_SAMPLE_MAX_US * 1000000 / CLK_PERIOD_PS;
	localparam int T3_MIN_PS = 100000;
	localparam int T3_CYC = (T3_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int T6_MIN_PS = 100000;
	localparam int T6_CYC = (T6_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ************************************************
	// Register map
	// ************************************************
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_T1 = 8'h04;
	localparam logic [7:0] ADDR_T8 = 8'h08;
	localparam logic [7:0] ADDR_T2 = 8'h0C;
	localparam logic [7:0] ADDR_CMD = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;
	localparam int CFG_DIV_LSB = 0;
	localparam int CFG_TXPRI_LSB = 16;
	localparam int CFG_RXPRI_LSB = 18;
	localparam int CFG_TWOPRI_BIT = 20;
	localparam int CFG_TRPRI_BIT = 21;
	localparam int CFG_LOCPRI_LSB = 22;
	localparam int CMD_RESEND_BIT = 0;
	localparam logic [13:0] T1_RST = 14'h0000;
	localparam logic [13:0] TGAP_RST = 14'(T_GAP_MIN_CYC);

	// ************************************************
	// Message format
	// ************************************************
	localparam int TYPE_LSB = 0;
	localparam int PAY_LSB = 3;
	localparam logic [2:0] MSG_REALTIME = 3'h0;
	localparam logic [2:0] MSG_TRANSPORT = 3'h1;
	localparam logic [2:0] MSG_INACTIVE = 3'h3;
	localparam logic [2:0] MSG_SCANFREQ = 3'h5;
	localparam logic [2:0] MSG_VENDOR = 3'h7;

	// External radio request as decoded from the link
	typedef struct packed {
		logic frame_sync;
		logic rx_req;
		logic tx_req;
		logic [1:0] pattern;
		logic [1:0] tx_pri;
		logic [1:0] rx_pri;
	} rci_ext_req_s;

	// Discrete handshake sequencer
	typedef enum logic [2:0] {
		PTA_IDLE = 3'b000,
		PTA_WAIT_P0 = 3'b001,
		PTA_WAIT_P1 = 3'b010,
		PTA_WAIT_TR = 3'b011,
		PTA_DECIDE = 3'b100,
		PTA_GRANT = 3'b101,
		PTA_RELEASE = 3'b110
	} rci_pta_e;

endpackage

// ===== hw/rci_uart_tx.sv
`timescale 1ns/10ps
`default_nettype none
module rci_uart_tx
	import rci_pkg::*;
(
	input wire logic i_clk, // System clock
	input wire logic i_arst_n, // Async reset, active low
	input wire logic [15:0] i_div, // Clocks per bit
	input wire logic i_valid, // Byte offered
	input wire logic [7:0] i_data, // Byte to send
	output logic o_ready, // Idle, byte taken when valid
	output logic o_line // Serial line, idles high
);

	// ************************************************
	// Shifter
	// ************************************************
	logic [8:0] shift_q; // Data then stop bit
	logic [3:0] bits_q; // Bits shifted so far
	logic [15:0] cnt_q; // Bit period counter
	logic busy_q; // Frame in progress
	logic line_q; // Line driver

	assign o_ready = ~busy_q;
	assign o_line = line_q;

	// Start bit, eight data bits LSB first, one stop bit
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			shift_q <= 9'h1FF;
			bits_q <= 4'h0;
			cnt_q <= 16'h0000;
			busy_q <= 1'b0;
			line_q <= 1'b1;
		end else if (!busy_q) begin
			if (i_valid) begin // Load and drive start bit
				shift_q <= {1'b1, i_data};
				bits_q <= 4'h0;
				cnt_q <= 16'h0000;
				busy_q <= 1'b1;
				line_q <= 1'b0;
			end
		end else if (cnt_q >= i_div - 16'h0001) begin
			cnt_q <= 16'h0000;
			if (bits_q == 4'h9) begin // Stop bit done
				busy_q <= 1'b0;
			end else begin
				line_q <= shift_q[0];
				shift_q <= {1'b1, shift_q[8:1]};
				bits_q <= bits_q + 4'h1;
			end
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// ************************************************
	// Checks
	// ************************************************
	chk_start_bit: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_valid && !busy_q) |=> !line_q)
		else $error("start bit not driven low");
	chk_stop_high: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		$fell(busy_q) |-> line_q)
		else $error("frame ended without high stop bit");

endmodule
`default_nettype wire

// ===== hw/rci_uart_rx.sv
`timescale 1ns/10ps
`default_nettype none
module rci_uart_rx
	import rci_pkg::*;
(
	input wire logic i_clk, // System clock
	input wire logic i_arst_n, // Async reset, active low
	input wire logic [15:0] i_div, // Clocks per bit
	input wire logic i_line, // Serial line from pin
	output logic o_valid, // One-cycle byte strobe
	output logic [7:0] o_data // Received byte
);

	// ************************************************
	// Receiver
	// ************************************************
	logic sync1_q; // First synchroniser stage
	logic sync2_q; // Second synchroniser stage
	logic busy_q; // Frame in progress
	logic [3:0] bits_q; // 0 start, 1-8 data, 9 stop
	logic [15:0] cnt_q; // Counts down to sample point
	logic [7:0] shift_q; // Data assembly
	logic valid_q; // Byte strobe
	logic [7:0] data_q; // Byte output

	assign o_valid = valid_q;
	assign o_data = data_q;

	// Two flops before the line is looked at
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= i_line;
			sync2_q <= sync1_q;
		end
	end

	// Mid-bit sampling; bad start or stop drops the byte
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			busy_q <= 1'b0;
			bits_q <= 4'h0;
			cnt_q <= 16'h0000;
			shift_q <= 8'h00;
			valid_q <= 1'b0;
			data_q <= 8'h00;
		end else begin
			valid_q <= 1'b0;
			if (!busy_q) begin
				if (!sync2_q) begin // Falling edge: start
					busy_q <= 1'b1;
					bits_q <= 4'h0;
					cnt_q <= {1'b0, i_div[15:1]};
				end
			end else if (cnt_q != 16'h0000) begin
				cnt_q <= cnt_q - 16'h0001;
			end else begin
				cnt_q <= i_div - 16'h0001;
				bits_q <= bits_q + 4'h1;
				if (bits_q == 4'h0) begin // Glitch check
					busy_q <= ~sync2_q;
				end else if (bits_q == 4'h9) begin // Stop bit
					busy_q <= 1'b0;
					valid_q <= sync2_q;
					data_q <= shift_q;
				end else begin // LSB arrives first
					shift_q <= {sync2_q, shift_q[7:1]};
				end
			end
		end
	end

	// ************************************************
	// Checks
	// ************************************************
	chk_stop_seen: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		valid_q |-> ($past(sync2_q) && $past(bits_q) == 4'h9))
		else $error("byte accepted without valid stop bit");

endmodule
`default_nettype wire

// ===== hw/rci_top.sv
`timescale 1ns/10ps
`default_nettype none
module rci_top
	import rci_pkg::*;
#(
	parameter int P_SAMPLE_MAX_CYC = T_SAMPLE_MAX_CYC // Longest sample delay
)
(
	input wire logic i_clk, // 125 MHz clock
	input wire logic i_arst_n, // Async reset, active low
	input wire logic [7:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic i_serial_in_line, // Message link in
	output logic o_serial_out_line, // Message link out
	input wire logic i_pta_request, // Discrete request pin
	input wire logic i_pta_priority, // Discrete priority pin
	input wire logic i_pta_state, // Discrete state pin
	output logic o_grant, // Discrete grant pin
	input wire logic [3:0] i_local_activity, // Arbiter winners
	input wire logic i_wake, // Wake-up pulse
	output rci_ext_req_s o_ext_req // Link request to arbiter
);

	// ************************************************
	// Helpers
	// ************************************************
	// Mapped register check, used by the error path
	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == ADDR_CFG) || (a == ADDR_T1) || (a == ADDR_T8) ||
			(a == ADDR_T2) || (a == ADDR_CMD) || (a == ADDR_STAT);
	endfunction

	// Keep a programmed delay inside its legal window
	function automatic logic [13:0] clamp_t(input logic [13:0] v,
		input logic [13:0] lo, input logic [13:0] hi);
		clamp_t = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// ************************************************
	// Declarations
	// ************************************************
	logic [15:0] cfg_div_q; // Clocks per bit
	logic [1:0] dflt_txpri_q; // Fallback tx priority
	logic [1:0] dflt_rxpri_q; // Fallback rx priority
	logic two_pri_q; // Two priority bits on pin
	logic tr_on_pri_q; // Tx/Rx info on priority pin
	logic [1:0] loc_pri_q; // Priority of own traffic
	logic [13:0] t1_q; // First sample delay
	logic [13:0] t8_q; // Second bit gap
	logic [13:0] t2_q; // Tx/Rx info gap
	logic pready_q; // APB answer
	logic pslverr_q; // APB error answer
	logic [31:0] prdata_q; // APB read data
	logic [31:0] rd_val; // Read mux
	logic apb_acc; // First access cycle
	logic wr_en; // Write commits
	logic [2:0] pin_raw; // Pins before sync
	logic [2:0] pin_m_q; // First sync stage
	logic [2:0] pin_s_q; // Second sync stage
	logic req_s; // Synced request
	logic pri_s; // Synced priority
	logic state_s; // Synced state
	rci_pta_e state_q; // Handshake sequencer
	logic [13:0] cnt_q; // Delay counter
	logic [13:0] tgt; // Current delay target
	logic cnt_hit; // Delay reached
	logic [2:0] info_q; // {tx/rx, pri1, pri0}
	logic [1:0] pta_pri; // Collected priority
	logic allow; // Arbiter lets ext radio in
	logic grant_q; // Grant driver
	logic rx_valid; // Byte received
	logic [7:0] rx_data; // Received byte
	logic [4:0] rx_pay; // Received payload
	rci_ext_req_s ext_q; // Decoded link request
	logic last_rt_q; // Previous byte was type 0
	logic [4:0] inact_q; // Inactivity duration
	logic [4:0] scan_q; // Scan frequency code
	logic resend_q; // Resend request pending
	logic [3:0] act_sent_q; // Activity last reported
	logic tx_valid; // Byte to send
	logic [7:0] tx_data; // Byte contents
	logic tx_ready; // Transmitter idle
	logic tx_fire; // Byte handed over

	// ************************************************
	// APB slave
	// ************************************************
	assign apb_acc = psel & penable & ~pready_q;
	assign wr_en = psel & penable & pready_q & pwrite;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// Read mux; unmapped reads zero
	always_comb begin
		unique case (paddr)
			ADDR_CFG: rd_val = {8'h00, loc_pri_q, tr_on_pri_q, two_pri_q,
				dflt_rxpri_q, dflt_txpri_q, cfg_div_q};
			ADDR_T1: rd_val = {18'h00000, t1_q};
			ADDR_T8: rd_val = {18'h00000, t8_q};
			ADDR_T2: rd_val = {18'h00000, t2_q};
			ADDR_STAT: rd_val = {14'h0000, info_q, grant_q, act_sent_q, scan_q, inact_q};
			default: rd_val = 32'h00000000;
		endcase
	end

	// One wait state, then answer for one cycle
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= apb_acc;
			pslverr_q <= apb_acc & ~reg_hit(paddr);
			prdata_q <= (apb_acc & ~pwrite) ? rd_val : 32'h00000000;
		end
	end

	// Configuration writes
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg_div_q <= DIV_RST;
			dflt_txpri_q <= 2'h0;
			dflt_rxpri_q <= 2'h0;
			two_pri_q <= 1'b0;
			tr_on_pri_q <= 1'b0;
			loc_pri_q <= 2'h0;
			t1_q <= T1_RST;
			t8_q <= TGAP_RST;
			t2_q <= TGAP_RST;
		end else if (wr_en) begin
			unique case (paddr)
				ADDR_CFG: begin
					cfg_div_q <= (pwdata[15:0] < DIV_MIN) ? DIV_MIN : pwdata[15:0];
					dflt_txpri_q <= pwdata[CFG_TXPRI_LSB +: 2];
					dflt_rxpri_q <= pwdata[CFG_RXPRI_LSB +: 2];
					two_pri_q <= pwdata[CFG_TWOPRI_BIT];
					tr_on_pri_q <= pwdata[CFG_TRPRI_BIT];
					loc_pri_q <= pwdata[CFG_LOCPRI_LSB +: 2];
				end
				ADDR_T1: t1_q <= pwdata[13:0];
				ADDR_T8: t8_q <= pwdata[13:0];
				ADDR_T2: t2_q <= pwdata[13:0];
				default: begin
				end
			endcase
		end
	end

	// ************************************************
	// Message link receive side
	// ************************************************
	rci_uart_rx u_rx (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_div(cfg_div_q),
		.i_line(i_serial_in_line),
		.o_valid(rx_valid),
		.o_data(rx_data)
	);

	assign rx_pay = rx_data[PAY_LSB +: 5];
	assign o_ext_req = ext_q;

	// Request and priority decode
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ext_q <= '0;
			last_rt_q <= 1'b0;
		end else if (rx_valid) begin
			last_rt_q <= (rx_data[TYPE_LSB +: 3] == MSG_REALTIME);
			if (rx_data[TYPE_LSB +: 3] == MSG_REALTIME) begin
				ext_q.frame_sync <= rx_pay[0];
				ext_q.rx_req <= rx_pay[1];
				ext_q.tx_req <= rx_pay[2];
				ext_q.pattern <= rx_pay[4:3];
				ext_q.tx_pri <= dflt_txpri_q;
				ext_q.rx_pri <= dflt_rxpri_q;
			end else if (rx_data[TYPE_LSB +: 3] == MSG_VENDOR && last_rt_q && !rx_pay[0]) begin
				ext_q.tx_pri <= rx_pay[2:1];
				ext_q.rx_pri <= rx_pay[4:3];
			end
		end
	end

	// Inactivity and scan frequency records
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			inact_q <= 5'h00;
			scan_q <= 5'h00;
		end else if (rx_valid) begin
			if (rx_data[TYPE_LSB +: 3] == MSG_INACTIVE) begin
				inact_q <= rx_pay;
			end
			if (rx_data[TYPE_LSB +: 3] == MSG_SCANFREQ) begin
				scan_q <= rx_pay;
			end
		end
	end

	// ************************************************
	// Message link transmit side
	// ************************************************
	// Resend request first, then any activity change
	always_comb begin
		tx_valid = resend_q | (i_local_activity != act_sent_q);
		if (resend_q) begin
			tx_data = {4'h0, 1'b1, MSG_TRANSPORT};
		end else begin
			tx_data = {1'b0, i_local_activity, MSG_REALTIME};
		end
	end
	assign tx_fire = tx_valid & tx_ready;

	// Pending resend: a new wake beats the clear
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			resend_q <= 1'b0;
		end else if (i_wake || (wr_en && paddr == ADDR_CMD && pwdata[CMD_RESEND_BIT])) begin
			resend_q <= 1'b1;
		end else if (tx_fire) begin
			resend_q <= 1'b0;
		end
	end

	// Last reported activity
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			act_sent_q <= 4'h0;
		end else if (tx_fire && !resend_q) begin
			act_sent_q <= i_local_activity;
		end
	end

	rci_uart_tx u_tx (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_div(cfg_div_q),
		.i_valid(tx_valid),
		.i_data(tx_data),
		.o_ready(tx_ready),
		.o_line(o_serial_out_line)
	);

	// ************************************************
	// Discrete handshake
	// ************************************************
	assign pin_raw = {i_pta_state, i_pta_priority, i_pta_request};
	assign req_s = pin_s_q[0];
	assign pri_s = pin_s_q[1];
	assign state_s = pin_s_q[2];

	// Two-flop synchroniser per pin
	for (genvar g = 0; g < 3; g++) begin : g_sync
		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				pin_m_q[g] <= 1'b0;
				pin_s_q[g] <= 1'b0;
			end else begin
				pin_m_q[g] <= pin_raw[g];
				pin_s_q[g] <= pin_m_q[g];
			end
		end
	end

	// Delay target of the current state
	always_comb begin
		unique case (state_q)
			PTA_WAIT_P0: tgt = clamp_t(t1_q, 14'h0000, 14'(P_SAMPLE_MAX_CYC));
			PTA_WAIT_P1: tgt = clamp_t(t8_q, TGAP_RST, 14'(P_SAMPLE_MAX_CYC)) - 14'h0001;
			PTA_WAIT_TR: tgt = clamp_t(t2_q, TGAP_RST, 14'(P_SAMPLE_MAX_CYC)) - 14'h0001;
			PTA_DECIDE: tgt = 14'(T3_CYC - 1);
			PTA_RELEASE: tgt = 14'(T6_CYC - 1);
			default: tgt = 14'h0000;
		endcase
	end
	assign cnt_hit = (cnt_q == tgt);

	// Sequencer: sample, decide, hold, release
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q <= PTA_IDLE;
			cnt_q <= 14'h0000;
		end else if (!req_s && state_q != PTA_IDLE && state_q != PTA_RELEASE) begin
			state_q <= PTA_RELEASE;
			cnt_q <= 14'h0000;
		end else if (state_q == PTA_IDLE || state_q == PTA_GRANT || !cnt_hit) begin
			cnt_q <= (state_q == PTA_IDLE || state_q == PTA_GRANT) ? 14'h0000 : cnt_q + 14'h0001;
			if (state_q == PTA_IDLE && req_s) begin
				state_q <= PTA_WAIT_P0;
			end
		end else begin
			cnt_q <= 14'h0000;
			unique case (state_q)
				PTA_WAIT_P0: state_q <= two_pri_q ? PTA_WAIT_P1 :
					(tr_on_pri_q ? PTA_WAIT_TR : PTA_DECIDE);
				PTA_WAIT_P1: state_q <= tr_on_pri_q ? PTA_WAIT_TR : PTA_DECIDE;
				PTA_WAIT_TR: state_q <= PTA_DECIDE;
				PTA_DECIDE: state_q <= PTA_GRANT;
				default: state_q <= PTA_IDLE;
			endcase
		end
	end

	// Priority and tx/rx capture
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			info_q <= 3'h0;
		end else if (req_s && cnt_hit) begin
			if (state_q == PTA_WAIT_P0) begin
				info_q[0] <= pri_s;
				info_q[1] <= 1'b0;
				if (!tr_on_pri_q) begin // Parallel variant uses state pin
					info_q[2] <= state_s;
				end
			end else if (state_q == PTA_WAIT_P1) begin
				info_q[1] <= pri_s;
			end else if (state_q == PTA_WAIT_TR) begin
				info_q[2] <= pri_s;
			end
		end
	end

	// Grant policy: higher priority than own traffic, or medium free
	assign pta_pri = two_pri_q ? {info_q[1], info_q[0]} : {1'b0, info_q[0]};
	assign allow = (pta_pri > loc_pri_q) || (i_local_activity == 4'h0);
	assign o_grant = grant_q;

	// Grant driver with preemption
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			grant_q <= 1'b0;
		end else if ((state_q == PTA_DECIDE && cnt_hit && req_s) ||
			(state_q == PTA_GRANT && req_s)) begin
			grant_q <= allow;
		end else if (state_q == PTA_IDLE || (state_q == PTA_RELEASE && cnt_hit)) begin
			grant_q <= 1'b0;
		end
	end

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);

	chk_grant_release: assert property (
		($fell(req_s) && state_q != PTA_IDLE && state_q != PTA_RELEASE)
		|-> ##14 (state_q == PTA_IDLE && !grant_q))
		else $error("grant not released 14 cycles after request");
	chk_decide_time: assert property (
		$rose(state_q == PTA_DECIDE) |-> ##13 (state_q != PTA_DECIDE))
		else $error("grant decision not 13 cycles after collection");
	chk_decide_quiet: assert property (
		(state_q == PTA_DECIDE) |-> !grant_q)
		else $error("grant raised before decision was ready");
	chk_first_sample: assert property (
		(state_q == PTA_WAIT_P0 && cnt_hit && req_s) |=> info_q[0] == $past(pri_s))
		else $error("first priority bit not captured");
	chk_second_gap: assert property (
		(state_q == PTA_WAIT_P1 && cnt_hit) |-> (cnt_q >= 14'(T_GAP_MIN_CYC - 1)))
		else $error("second priority sample too early");
	chk_state_ignored: assert property (
		(state_q == PTA_WAIT_P0 && cnt_hit && tr_on_pri_q) |=> $stable(info_q[2]))
		else $error("state pin used in serial variant");
	chk_preempt_drop: assert property (
		(state_q == PTA_GRANT && req_s && !allow) |=> !grant_q)
		else $error("grant kept under higher priority traffic");
	chk_report_change: assert property (
		(i_local_activity != act_sent_q && tx_ready && !resend_q)
		|=> act_sent_q == $past(i_local_activity))
		else $error("activity change not reported");
	chk_resend_msg: assert property (
		(resend_q && tx_ready) |-> (tx_valid && tx_data == 8'h09) ##1 !resend_q || $past(i_wake))
		else $error("resend request not sent");
	chk_default_pri: assert property (
		(rx_valid && rx_data[2:0] == MSG_REALTIME) |=> ext_q.tx_pri == $past(dflt_txpri_q))
		else $error("fallback priority not applied");
	chk_vendor_pri: assert property (
		(rx_valid && rx_data[2:0] == MSG_VENDOR && last_rt_q && !rx_data[3])
		|=> ext_q.rx_pri == $past(rx_data[7:6]))
		else $error("vendor priority not applied");

endmodule
`default_nettype wire

// ===== verif/rci_radio_model.sv
`timescale 1ns/10ps
`default_nettype none
module rci_radio_model #(
	parameter int P_DIV = 31 // Clocks per bit
)
(
	input wire logic i_clk, // System clock
	input wire logic i_line, // Message line from device
	output logic o_line // Message line into device
);
	logic [7:0] rx_q[$]; // Bytes heard from device
	logic [7:0] sh; // Receive shift register
	initial o_line = 1'b1;
	// Send one byte: start, eight bits low first, stop; line rests high
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		begin
			f = {1'b1, b, 1'b0};
			for (int i = 0; i < 10; i++) begin
				o_line <= f[i];
				repeat (P_DIV) @(posedge i_clk);
			end
		end
	endtask
	// Hear device frames at mid-bit, keep those with a good stop bit
	always begin
		@(negedge i_line);
		repeat (P_DIV / 2) @(posedge i_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (P_DIV) @(posedge i_clk);
			sh[i] = i_line;
		end
		repeat (P_DIV) @(posedge i_clk);
		if (i_line) rx_q.push_back(sh);
	end
endmodule
`default_nettype wire

// ===== verif/test_radio_coexistence_interface.sv
`timescale 1ns/10ps
`default_nettype none
module test_radio_coexistence_interface
	import rci_pkg::*;
;
	// ****
	// Stimulus and wiring
	// ****
	typedef struct packed {logic [7:0] b; logic [8:0] req; logic [9:0] st;} rci_row_s;
	rci_row_s rows[6] = '{'{8'h30, 9'h0C9, 10'h000}, '{8'hF7, 9'h0CF, 10'h000},
		'{8'h53, 9'h0CF, 10'h00A}, '{8'hAD, 9'h0CF, 10'h2AA},
		'{8'h07, 9'h0CF, 10'h2AA}, '{8'h08, 9'h109, 10'h2AA}};
	logic i_clk = 1'b0, i_arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, sin, sout, req = 1'b0, pri = 1'b0, st = 1'b0, grant, wake = 1'b0, er;
	logic [3:0] act = 4'h0;
	rci_ext_req_s ext_req;
	int miscompares = 0;
	int total_checks = 0;
	always #4 i_clk = ~i_clk;
	rci_top #(.P_SAMPLE_MAX_CYC(64)) uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .i_serial_in_line(sin), .o_serial_out_line(sout),
		.i_pta_request(req), .i_pta_priority(pri), .i_pta_state(st), .o_grant(grant),
		.i_local_activity(act), .i_wake(wake), .o_ext_req(ext_req));
	rci_radio_model m (.i_clk(i_clk), .i_line(sout), .o_line(sin));
	// ****
	// Shared tasks
	// ****
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer, held until pready; one idle edge so the next setup never collides
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		begin
			psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
			@(posedge i_clk);
			penable <= 1'b1;
			do begin
				@(posedge i_clk);
			end while (pready !== 1'b1);
			rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
			@(posedge i_clk);
		end
	endtask
	task automatic summarize();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog against hangs
	initial begin
		#100000;
		miscompares++;
		summarize();
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		chk("idle line", 32'(sout), 32'h1);
		chk("grant", 32'(grant), 32'h0);
		apb(1'b0, ADDR_CFG, 32'h0); chk("cfg", rd, 32'(DIV_RST));
		apb(1'b0, ADDR_T8, 32'h0); chk("t8", rd, 32'h4);
		apb(1'b0, 8'h20, 32'h0); chk("unmapped", {rd[30:0], er}, 32'h1);
		apb(1'b1, ADDR_CFG, 32'h00060005);
		apb(1'b0, ADDR_CFG, 32'h0); chk("cfg clamp", rd, 32'h0006001F);
		apb(1'b1, ADDR_T1, 32'hA);
		foreach (rows[i]) begin
			m.send(rows[i].b);
			repeat (5) @(posedge i_clk);
			chk("ext req", 32'(ext_req), 32'(rows[i].req));
			apb(1'b0, ADDR_STAT, 32'h0); chk("stat", 32'(rd[9:0]), 32'(rows[i].st));
		end
		// Wake a cycle ahead of the activity change, so the resend takes the first slot
		wake <= 1'b1;
		@(posedge i_clk);
		wake <= 1'b0;
		act <= 4'h5;
		for (int n = 0; n < 1500 && m.rx_q.size() < 2; n++) @(posedge i_clk);
		chk("frames", 32'(m.rx_q.size()), 32'h2);
		chk("resend", 32'(m.rx_q[0]), 32'h09);
		chk("report", 32'(m.rx_q[1]), 32'h28);
		pri <= 1'b1;
		st <= 1'b1;
		@(posedge i_clk);
		req <= 1'b1;
		repeat (20) @(posedge i_clk);
		chk("grant early", 32'(grant), 32'h0);
		repeat (12) @(posedge i_clk);
		chk("grant", 32'(grant), 32'h1);
		apb(1'b0, ADDR_STAT, 32'h0); chk("stat pta", 32'(rd[17:10]), 32'hB5);
		apb(1'b1, ADDR_CFG, 32'h00C6001F);
		repeat (3) @(posedge i_clk);
		chk("preempt", 32'(grant), 32'h0);
		apb(1'b1, ADDR_CFG, 32'h0006001F);
		repeat (3) @(posedge i_clk);
		chk("regain", 32'(grant), 32'h1);
		req <= 1'b0;
		repeat (10) @(posedge i_clk);
		chk("grant hold", 32'(grant), 32'h1);
		repeat (10) @(posedge i_clk);
		chk("grant drop", 32'(grant), 32'h0);
		// Serial variant: two priority bits and tx/rx on the priority pin, state pin low
		apb(1'b1, ADDR_CFG, 32'h00B6001F);
		st <= 1'b0;
		req <= 1'b1;
		repeat (30) @(posedge i_clk);
		chk("serial early", 32'(grant), 32'h0);
		repeat (10) @(posedge i_clk);
		chk("serial grant", 32'(grant), 32'h1);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk("stat serial", 32'(rd[17:14]), 32'hF);
		req <= 1'b0;
		repeat (20) @(posedge i_clk);
		chk("serial drop", 32'(grant), 32'h0);
		// Software-queued resend
		apb(1'b1, ADDR_CMD, 32'h1);
		for (int n = 0; n < 1500 && m.rx_q.size() < 3; n++) @(posedge i_clk);
		chk("cmd resend", 32'(m.rx_q[2]), 32'h09);
		// Reset in mid-run clears outputs and registers
		i_arst_n <= 1'b0;
		@(posedge i_clk);
		chk("reset grant", 32'(grant), 32'h0);
		chk("reset req", 32'(ext_req), 32'h0);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		apb(1'b0, ADDR_CFG, 32'h0);
		chk("cfg reset", rd, 32'(DIV_RST));
		summarize();
	end
endmodule
`default_nettype wire
